// file: bench/pisw_assertions.sv
// Port checks of the interrupt and standby block
module pisw_assertions
  import pisw_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Core side and reset causes
  input wire logic irq_ack,
  input wire logic irq_ret,
  input wire logic irq_req,
  input wire logic [16:0] irq_vec_addr,
  input wire pisw_lvl_t irq_level,
  input wire logic ext_reset_n,
  input wire logic wdt_reset,
  input wire logic low_voltage_detect,
  // Standby gating
  input wire pisw_mode_t stby_mode,
  input wire logic cpu_run,
  input wire logic periph_run,
  input wire logic base_timer_run,
  input wire logic osc_cf_en,
  input wire logic osc_rc_en,
  input wire logic osc_xt_en
);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  wire sys_cause = !ext_reset_n || wdt_reset || low_voltage_detect; // Any system reset cause
  wire [5:0] gate = {cpu_run, periph_run, base_timer_run, osc_cf_en, osc_rc_en, osc_xt_en};
  // Top-level grant, then three cycles with no return
  sequence s_top_taken;
    irq_req && irq_ack && (irq_level == LVL_TOP);
  endsequence
  sequence s_no_ret;
    (!irq_ret)[*3];
  endsequence
  AST_VEC_ADDR: assert property (
    irq_req |-> (irq_vec_addr[2:0] == 3'h3) && (irq_vec_addr < 17'h0004c))
    else $error("vector address off grid");
  AST_LVL_SET: assert property (
    irq_req |-> irq_level != LVL_NONE)
    else $error("request without level");
  AST_TOP_PIN: assert property (
    irq_req && (irq_level == LVL_TOP) |-> irq_vec_addr <= 17'h0000b)
    else $error("top level on a non-pin vector");
  AST_ACK_DROP: assert property (
    irq_req && irq_ack |=> !irq_req)
    else $error("request held after ack");
  AST_TOP_REFUSE: assert property (
    s_top_taken ##1 s_no_ret |-> !irq_req)
    else $error("request under top service");
  AST_HALT_GATE: assert property (
    stby_mode == MODE_HALT |-> !cpu_run && periph_run && base_timer_run)
    else $error("halt gating wrong");
  AST_HOLD_GATE: assert property (
    stby_mode == MODE_HOLD |-> gate == 6'h00)
    else $error("hold gating wrong");
  AST_XHOLD_GATE: assert property (
    stby_mode == MODE_XHOLD |-> gate[5:1] == 5'h04)
    else $error("crystal hold gating wrong");
  AST_XT_KEEP: assert property (
    (stby_mode == MODE_XHOLD) && ($past(stby_mode) == MODE_XHOLD) |-> $stable(osc_xt_en))
    else $error("crystal enable moved");
  AST_SYS_WAKE: assert property (
    (stby_mode != MODE_RUN) && sys_cause |=> stby_mode == MODE_RUN)
    else $error("no wake on system reset cause");
  AST_HALT_IRQ: assert property (
    (stby_mode == MODE_HALT) && irq_req |-> ##[0:1] stby_mode == MODE_RUN)
    else $error("halt kept under request");
endmodule : pisw_assertions

// file: bench/pisw_core_model.sv
// Behavioural core that takes and returns interrupts
module pisw_core_model
  import pisw_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Bench control
  input wire logic ack_en,
  input wire logic ret_cmd,
  input wire logic [7:0] ack_delay,
  // Interrupt side
  input wire logic irq_req,
  input wire logic cpu_run,
  output logic irq_ack,
  output logic irq_ret
);
  logic [7:0] wait_cnt; // Cycles the request was seen
  // Take a shown vector after a set delay, return on command
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irq_ack <= 1'b0;
      irq_ret <= 1'b0;
      wait_cnt <= 8'h00;
    end
    else
    begin
      irq_ret <= ret_cmd;
      irq_ack <= 1'b0;
      if (irq_req && cpu_run && ack_en && !irq_ack)
      begin
        if (wait_cnt >= ack_delay)
        begin
          irq_ack <= 1'b1;
          wait_cnt <= 8'h00;
        end
        else
          wait_cnt <= wait_cnt + 8'h01;
      end
    end
  end
endmodule : pisw_core_model

// file: bench/testbench.sv
// Self-checking bench of the interrupt and standby block
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin failures++; \
  $display("Error %s expected %0h seen %0h", nm, e, g); end end
module testbench
  import pisw_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys, rst_n, ce, reg_wr, reg_rd, irq_ack, irq_ret, irq_req, ext_reset_n;
  logic wdt_reset, low_voltage_detect, ack_en, ret_cmd;
  logic cpu_run, periph_run, base_timer_run, osc_cf_en, osc_rc_en, osc_xt_en;
  logic [4:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, rd_data, ack_delay;
  logic [23:0] src_evt;
  logic [16:0] irq_vec_addr;
  pisw_lvl_t irq_level;
  pisw_mode_t stby_mode;
  int failures, compares;
  wire [5:0] gate = {cpu_run, periph_run, base_timer_run, osc_cf_en, osc_rc_en, osc_xt_en};
  // Arbitration rows: events, level select, winner, level, flag list
  typedef struct {logic [23:0] e; logic [9:0] s; logic [3:0] v; pisw_lvl_t l;
    logic [7:0] f;} pisw_arb_t;
  pisw_arb_t arb[10] = '{'{24'h1, 10'h0, 4'h0, LVL_LOW, 8'h1},
    '{24'h100002, 10'h2, 4'h1, LVL_TOP, 8'h1}, '{24'h108, 10'h0, 4'h2, LVL_LOW, 8'h2},
    '{24'h81, 10'h8, 4'h3, LVL_HIGH, 8'h2}, '{24'h400, 10'h0, 4'h4, LVL_LOW, 8'h1},
    '{24'h6800, 10'h60, 4'h5, LVL_HIGH, 8'h1}, '{24'h4001, 10'h40, 4'h6, LVL_HIGH, 8'h2},
    '{24'h8000, 10'h0, 4'h7, LVL_LOW, 8'h1}, '{24'h20000, 10'h0, 4'h8, LVL_LOW, 8'h1},
    '{24'h800002, 10'h200, 4'h9, LVL_HIGH, 8'h8}};
  // Standby rows: mode, pin level modes, events, reset causes, wake, gating
  typedef struct {pisw_mode_t m; logic [1:0] p; logic [23:0] e; logic [2:0] c; logic w;
    logic [5:0] g;} pisw_stb_t;
  pisw_stb_t stb[12] = '{'{MODE_HALT, 2'h0, 24'h10, 3'h0, 1'b1, 6'h1f},
    '{MODE_HALT, 2'h0, 24'h0, 3'h1, 1'b1, 6'h1f}, '{MODE_HOLD, 2'h0, 24'h100, 3'h0, 1'b0, 6'h0},
    '{MODE_HOLD, 2'h0, 24'h1, 3'h0, 1'b0, 6'h0}, '{MODE_HOLD, 2'h1, 24'h1, 3'h0, 1'b1, 6'h0},
    '{MODE_HOLD, 2'h2, 24'h2, 3'h0, 1'b1, 6'h0}, '{MODE_HOLD, 2'h0, 24'h100000, 3'h0, 1'b1, 6'h0},
    '{MODE_HOLD, 2'h0, 24'h80, 3'h0, 1'b1, 6'h0}, '{MODE_HOLD, 2'h0, 24'h0, 3'h4, 1'b1, 6'h0},
    '{MODE_XHOLD, 2'h0, 24'h20, 3'h0, 1'b1, 6'h09}, '{MODE_XHOLD, 2'h0, 24'h400, 3'h0, 1'b0, 6'h09},
    '{MODE_XHOLD, 2'h0, 24'h0, 3'h2, 1'b1, 6'h09}};
  // Design and far-side core
  pisw_top i_dut (.*);
  pisw_core_model i_core (.*);
  // 200 MHz clock
  initial
  begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : tick
  task automatic complete_run;
    if (failures == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : complete_run
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [4:0] a);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 rd_data = reg_rdata;
  endtask : rd
  // One-cycle source events and reset causes
  task automatic fire(input logic [23:0] e, input logic [2:0] c);
    @(posedge clk_sys);
    src_evt <= e;
    {low_voltage_detect, wdt_reset, ext_reset_n} <= c ^ 3'h1;
    @(posedge clk_sys);
    src_evt <= 24'h0;
    {low_voltage_detect, wdt_reset, ext_reset_n} <= 3'h1;
  endtask : fire
  task automatic do_reset;
    @(posedge clk_sys);
    rst_n <= 1'b0;
    tick(16);
    rst_n <= 1'b1;
  endtask : do_reset
  task automatic setup(input logic [9:0] s, input logic [1:0] p);
    wr(OFS_EN0, 8'hff);
    wr(OFS_EN1, 8'hff);
    wr(OFS_EN2, 8'hff);
    wr(OFS_LVL_LO, s[7:0]);
    wr(OFS_LVL_HI, {4'h0, p, s[9:8]});
  endtask : setup
  task automatic wait_req;
    for (int i = 0; i < 20 && irq_req !== 1'b1; i++)
      tick(1);
    if (irq_req !== 1'b1)
    begin
      failures++;
      complete_run();
    end
  endtask : wait_req
  task automatic ret;
    @(posedge clk_sys);
    ret_cmd <= 1'b1;
    @(posedge clk_sys);
    ret_cmd <= 1'b0;
    tick(3);
  endtask : ret
  // Main sequence
  initial
  begin
    {rst_n, ce, reg_wr, reg_rd, wdt_reset, low_voltage_detect, ack_en, ret_cmd} = 8'h40;
    {ext_reset_n, reg_addr, reg_wdata, src_evt, ack_delay} = 46'h200000000000;
    failures = 0;
    compares = 0;
    tick(16);
    `CHK("reset req", 1'b0, irq_req)
    `CHK("reset gating", 6'h3f, gate)
    rst_n <= 1'b1;
    ce <= 1'b0;
    wr(OFS_OSC, 8'h00);
    ce <= 1'b1;
    rd(OFS_OSC);
    `CHK("osc reg", 8'h07, rd_data)
    rd(5'h1f);
    `CHK("unmapped", 8'h00, rd_data)
    foreach (arb[k])
    begin
      do_reset;
      setup(arb[k].s, 2'h0);
      fire(arb[k].e, 3'h0);
      wait_req;
      `CHK("vector", VEC_BASE + {arb[k].v, 3'h0}, irq_vec_addr)
      `CHK("level", arb[k].l, irq_level)
      wr(OFS_LIST_SEL, {4'h0, arb[k].v});
      rd(OFS_LIST);
      `CHK("list", arb[k].f, rd_data)
    end
    foreach (stb[k])
    begin
      do_reset;
      setup(10'h000, stb[k].p);
      wr(OFS_STBY, {6'h00, stb[k].m});
      tick(2);
      `CHK("gating", stb[k].g, gate)
      fire(stb[k].e, stb[k].c);
      tick(4);
      `CHK("wake", stb[k].w ? MODE_RUN : stb[k].m, stby_mode)
    end
    do_reset;
    setup(10'h201, 2'h0);
    ack_delay <= 8'h02;
    ack_en <= 1'b1;
    fire(24'h100000, 3'h0);
    tick(8);
    fire(24'h000002, 3'h0);
    tick(6);
    `CHK("refused", 1'b0, irq_req)
    fire(24'h000001, 3'h0);
    wait_req;
    `CHK("top level", LVL_TOP, irq_level)
    tick(8);
    rd(OFS_SVC);
    `CHK("service", 3'h6, rd_data[2:0])
    ack_en <= 1'b0;
    wr(OFS_FLAG0, 8'h01);
    ret;
    wr(OFS_FLAG2, 8'h10);
    ret;
    wait_req;
    `CHK("resumed", 17'h0000b, irq_vec_addr)
    complete_run();
  end
endmodule : testbench
bind pisw_top pisw_assertions i_chk (.*);

// file: rtl/pisw_arbiter.sv
// Combinational priority arbiter over the ten interrupt vectors
module pisw_arbiter
  import pisw_pkg::*;
(
  // Requests and level configuration
  input wire logic [NUM_VEC-1:0] vec_req,
  input wire logic [NUM_VEC-1:0] vec_lvl_sel,
  input wire pisw_lvl_t svc_lvl,
  // Winner
  output logic win_valid,
  output logic [3:0] win_vec,
  output pisw_lvl_t win_lvl
);

  // ----------------------------------------------------------------
  // Level of one vector
  // ----------------------------------------------------------------
  function automatic pisw_lvl_t vec_level(input int v, input logic sel);
    if (!sel)
      vec_level = LVL_LOW;
    else if (v < 2)
      vec_level = LVL_TOP;
    else
      vec_level = LVL_HIGH;
  endfunction : vec_level

  // ----------------------------------------------------------------
  // Scan from the largest vector down; ties go to the smaller address
  // ----------------------------------------------------------------
  always_comb
  begin
    pisw_lvl_t lv;
    lv = LVL_NONE;
    win_valid = 1'b0;
    win_vec = 4'h0;
    win_lvl = LVL_NONE;
    for (int v = NUM_VEC - 1; v >= 0; v--)
    begin
      lv = vec_level(v, vec_lvl_sel[v]);
      // Higher level first, then smaller vector
      if (vec_req[v] && (lv > svc_lvl) && (lv >= win_lvl))
      begin
        win_valid = 1'b1;
        win_vec = v[3:0];
        win_lvl = lv;
      end
    end
  end

endmodule : pisw_arbiter

// file: rtl/pisw_pkg.sv
// Shared constants and types of the priority interrupt and standby wake block
package pisw_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int NUM_SRC = 24;
  localparam int NUM_VEC = 10;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    LVL_NONE = 2'b00,
    LVL_LOW  = 2'b01,
    LVL_HIGH = 2'b10,
    LVL_TOP  = 2'b11
  } pisw_lvl_t;

  typedef enum logic [1:0] {
    MODE_RUN   = 2'b00,
    MODE_HALT  = 2'b01,
    MODE_HOLD  = 2'b10,
    MODE_XHOLD = 2'b11
  } pisw_mode_t;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [4:0] OFS_FLAG0 = 5'h00;
  localparam logic [4:0] OFS_FLAG1 = 5'h01;
  localparam logic [4:0] OFS_FLAG2 = 5'h02;
  localparam logic [4:0] OFS_EN0 = 5'h03;
  localparam logic [4:0] OFS_EN1 = 5'h04;
  localparam logic [4:0] OFS_EN2 = 5'h05;
  localparam logic [4:0] OFS_LVL_LO = 5'h06;
  localparam logic [4:0] OFS_LVL_HI = 5'h07;
  localparam logic [4:0] OFS_STBY = 5'h08;
  localparam logic [4:0] OFS_OSC = 5'h09;
  localparam logic [4:0] OFS_SVC = 5'h0a;
  localparam logic [4:0] OFS_LIST_SEL = 5'h0b;
  localparam logic [4:0] OFS_LIST = 5'h0c;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int POS_EXT0_LEVEL = 2;
  localparam int POS_EXT1_LEVEL = 3;
  localparam logic [23:0] RST_EN = 24'h000000;
  localparam logic [9:0] RST_LVL = 10'h000;
  localparam logic [1:0] RST_EXT_LEVEL = 2'h0;
  localparam logic [2:0] RST_OSC = 3'h7;
  localparam logic [3:0] RST_LIST_SEL = 4'h0;

  // ----------------------------------------------------------------
  // Vector addresses
  // ----------------------------------------------------------------
  localparam logic [16:0] VEC_BASE = 17'h00003;
  localparam int VEC_STEP_SHIFT = 3;

  // ----------------------------------------------------------------
  // Source indices that matter to wake logic
  // ----------------------------------------------------------------
  localparam int SRC_EXT0 = 0;
  localparam int SRC_EXT1 = 1;
  localparam int SRC_EXT2 = 2;
  localparam int SRC_EXT4 = 4;
  localparam int SRC_REMOTE = 5;
  localparam int SRC_EXT5 = 7;
  localparam int SRC_BT0 = 8;
  localparam int SRC_BT1 = 9;
  localparam int SRC_PORT0 = 20;

  // First source of each vector; sources of a vector are contiguous
  function automatic logic [4:0] vec_first(input logic [3:0] v);
    case (v)
      4'h0: vec_first = 5'h00;
      4'h1: vec_first = 5'h01;
      4'h2: vec_first = 5'h02;
      4'h3: vec_first = 5'h06;
      4'h4: vec_first = 5'h0a;
      4'h5: vec_first = 5'h0b;
      4'h6: vec_first = 5'h0d;
      4'h7: vec_first = 5'h0f;
      4'h8: vec_first = 5'h11;
      4'h9: vec_first = 5'h14;
      default: vec_first = 5'h18;
    endcase
  endfunction : vec_first

endpackage : pisw_pkg

// file: rtl/pisw_standby.sv
// Standby mode sequencer with clock and peripheral gating
module pisw_standby
  import pisw_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic ce,
  // Mode entry and wake causes
  input wire logic enter,
  input wire pisw_mode_t enter_mode,
  input wire logic sys_wake,
  input wire logic irq_wake,
  input wire logic hold_wake,
  input wire logic xhold_wake,
  input wire logic [2:0] osc_ctl,
  // Gating outputs
  output pisw_mode_t mode,
  output logic cpu_run,
  output logic periph_run,
  output logic base_timer_run,
  output logic osc_cf_en,
  output logic osc_rc_en,
  output logic osc_xt_en
);

  pisw_mode_t next_mode;
  logic xt_keep; // Crystal state caught on entry to crystal hold

  // ----------------------------------------------------------------
  // Next mode
  // ----------------------------------------------------------------
  always_comb
  begin
    next_mode = mode;
    case (mode)
      MODE_RUN: if (enter && !sys_wake) next_mode = enter_mode;
      MODE_HALT: if (sys_wake || irq_wake) next_mode = MODE_RUN;
      MODE_HOLD: if (sys_wake || hold_wake) next_mode = MODE_RUN;
      MODE_XHOLD: if (sys_wake || hold_wake || xhold_wake) next_mode = MODE_RUN;
      default: next_mode = MODE_RUN;
    endcase
  end

  // ----------------------------------------------------------------
  // Mode register and gating flops
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mode <= MODE_RUN;
      xt_keep <= 1'b1;
      cpu_run <= 1'b1;
      periph_run <= 1'b1;
      base_timer_run <= 1'b1;
      osc_cf_en <= 1'b1;
      osc_rc_en <= 1'b1;
      osc_xt_en <= 1'b1;
    end
    else if (ce)
    begin
      mode <= next_mode;
      if (mode == MODE_RUN)
        xt_keep <= osc_ctl[2];
      cpu_run <= (next_mode == MODE_RUN);
      // Halt keeps peripherals and oscillators running
      periph_run <= (next_mode == MODE_RUN) || (next_mode == MODE_HALT);
      base_timer_run <= (next_mode != MODE_HOLD);
      osc_cf_en <= osc_ctl[0] && !next_mode[1];
      osc_rc_en <= osc_ctl[1] && !next_mode[1];
      case (next_mode)
        MODE_HOLD: osc_xt_en <= 1'b0;
        MODE_XHOLD: osc_xt_en <= (mode == MODE_RUN) ? osc_ctl[2] : xt_keep;
        default: osc_xt_en <= osc_ctl[2];
      endcase
    end
  end

endmodule : pisw_standby

// file: rtl/pisw_top.sv
// Priority interrupt controller with standby wake logic
//
// Contract
// - Three levels: low, high, highest
// - Refuse requests at or below service level
// - Highest level wins among simultaneous requests
// - Equal level: smallest vector address wins
// - 24 sources onto 10 vectors from 00003H
// - Pin vectors highest/low, others high/low
// - Readable source flag list per vector
// - Halt stops core, peripherals, oscillators run
// - Halt ends on reset or accepted interrupt
// - Full hold stops core, peripherals, oscillators
// - Full hold ends on reset, pin, port0
// - Pins zero/one wake only when level-detected
// - Crystal hold keeps base timer, crystal state
// - Crystal hold also wakes on timer, remote
module pisw_top
  import pisw_pkg::*;
(
  // Clock, reset, enable
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic ce,
  // Register port
  input wire logic [4:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Interrupt source events, one-cycle pulses
  input wire logic [NUM_SRC-1:0] src_evt,
  // System reset causes that end any standby mode
  input wire logic ext_reset_n,
  input wire logic wdt_reset,
  input wire logic low_voltage_detect,
  // Core side
  input wire logic irq_ack,
  input wire logic irq_ret,
  output logic irq_req,
  output logic [16:0] irq_vec_addr,
  output pisw_lvl_t irq_level,
  // Standby gating
  output pisw_mode_t stby_mode,
  output logic cpu_run,
  output logic periph_run,
  output logic base_timer_run,
  output logic osc_cf_en,
  output logic osc_rc_en,
  output logic osc_xt_en
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------

  // Byte lane of a 24-bit register selected by offset
  function automatic logic [7:0] byte_of(input logic [23:0] w, input logic [1:0] idx);
    case (idx)
      2'h0: byte_of = w[7:0];
      2'h1: byte_of = w[15:8];
      default: byte_of = w[23:16];
    endcase
  endfunction : byte_of

  // Write-one mask for the 24-bit registers
  function automatic logic [23:0] lane_mask(input logic [7:0] d, input logic [1:0] idx);
    case (idx)
      2'h0: lane_mask = {16'h0000, d};
      2'h1: lane_mask = {8'h00, d, 8'h00};
      default: lane_mask = {d, 16'h0000};
    endcase
  endfunction : lane_mask

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [NUM_SRC-1:0] pend; // Sticky source flags
  logic [NUM_SRC-1:0] src_en; // Per-source enables
  logic [NUM_VEC-1:0] vec_lvl_sel; // 1 = upper class of the vector
  logic [1:0] ext_level; // Pins zero/one in level-detect mode
  logic [2:0] osc_ctl; // Software oscillator enables
  logic [3:0] list_sel; // Vector picked for the flag list
  logic [2:0] svc_bits; // In-service levels: low, high, top
  pisw_lvl_t svc_lvl; // Current service level
  logic [NUM_SRC-1:0] active; // Pending and enabled
  logic [NUM_VEC-1:0] vec_req; // Per-vector request
  logic win_valid;
  logic [3:0] win_vec;
  pisw_lvl_t win_lvl;
  logic [23:0] clr_mask; // Flags cleared by this write
  logic [7:0] next_rdata;
  logic [7:0] flag_list; // Flags of the selected vector
  logic stby_enter;
  logic sys_wake;
  logic hold_wake;
  logic xhold_wake;
  logic is_flag_wr;
  logic is_en_wr;

  // ----------------------------------------------------------------
  // Write decode
  // ----------------------------------------------------------------
  assign is_flag_wr = reg_wr && (reg_addr == OFS_FLAG0 || reg_addr == OFS_FLAG1
                                 || reg_addr == OFS_FLAG2);
  assign is_en_wr = reg_wr && (reg_addr == OFS_EN0 || reg_addr == OFS_EN1
                               || reg_addr == OFS_EN2);
  assign clr_mask = is_flag_wr ? lane_mask(reg_wdata, reg_addr[1:0]) : 24'h000000;
  assign stby_enter = reg_wr && (reg_addr == OFS_STBY) && (reg_wdata[1:0] != 2'h0);

  // ----------------------------------------------------------------
  // Source flags: set beats clear in the same cycle
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      pend <= 24'h000000;
    else if (ce)
      pend <= (pend & ~clr_mask) | src_evt;
  end

  // ----------------------------------------------------------------
  // Enables
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      src_en <= RST_EN;
    else if (ce && is_en_wr)
    begin
      // Replace only the addressed byte
      case (reg_addr[1:0])
        2'h0: src_en[15:8] <= reg_wdata;
        2'h1: src_en[23:16] <= reg_wdata;
        default: src_en[7:0] <= reg_wdata;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Level selection and pin detect mode
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      vec_lvl_sel <= RST_LVL;
      ext_level <= RST_EXT_LEVEL;
    end
    else if (ce && reg_wr)
    begin
      // Vectors zero and one choose top/low, the rest high/low
      if (reg_addr == OFS_LVL_LO)
        vec_lvl_sel[7:0] <= reg_wdata;
      else if (reg_addr == OFS_LVL_HI)
      begin
        vec_lvl_sel[9:8] <= reg_wdata[1:0];
        ext_level <= reg_wdata[POS_EXT1_LEVEL:POS_EXT0_LEVEL];
      end
    end
  end

  // ----------------------------------------------------------------
  // Oscillator enables and list selector
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      osc_ctl <= RST_OSC;
      list_sel <= RST_LIST_SEL;
    end
    else if (ce && reg_wr)
    begin
      if (reg_addr == OFS_OSC)
        osc_ctl <= reg_wdata[2:0];
      else if (reg_addr == OFS_LIST_SEL)
        list_sel <= reg_wdata[3:0];
    end
  end

  // ----------------------------------------------------------------
  // Merge sources onto vectors
  // ----------------------------------------------------------------
  assign active = pend & src_en;

  always_comb
  begin
    logic [4:0] lo;
    logic [4:0] hi;
    lo = 5'h00;
    hi = 5'h00;
    vec_req = '0;
    for (int v = 0; v < NUM_VEC; v++)
    begin
      lo = vec_first(v[3:0]);
      hi = vec_first(4'(v + 1));
      // Several sources share one vector
      for (int s = 0; s < NUM_SRC; s++)
        if (s >= int'(lo) && s < int'(hi) && active[s])
          vec_req[v] = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Flag list of the selected vector, packed from bit 0
  // ----------------------------------------------------------------
  always_comb
  begin
    logic [4:0] lo;
    logic [4:0] hi;
    lo = vec_first(list_sel);
    hi = vec_first(list_sel + 4'h1);
    flag_list = 8'h00;
    for (int k = 0; k < 4; k++)
      if (int'(lo) + k < int'(hi))
        flag_list[k] = pend[int'(lo) + k];
  end

  // ----------------------------------------------------------------
  // Current service level from the in-service bits
  // ----------------------------------------------------------------
  always_comb
  begin
    if (svc_bits[2])
      svc_lvl = LVL_TOP;
    else if (svc_bits[1])
      svc_lvl = LVL_HIGH;
    else if (svc_bits[0])
      svc_lvl = LVL_LOW;
    else
      svc_lvl = LVL_NONE;
  end

  // ----------------------------------------------------------------
  // Arbitration
  // ----------------------------------------------------------------
  pisw_arbiter u_arb (
    .vec_req(vec_req),
    .vec_lvl_sel(vec_lvl_sel),
    .svc_lvl(svc_lvl),
    .win_valid(win_valid),
    .win_vec(win_vec),
    .win_lvl(win_lvl)
  );

  // ----------------------------------------------------------------
  // In-service tracking: return pops the top level, accept pushes
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      svc_bits <= 3'h0;
    else if (ce)
    begin
      logic [2:0] b;
      b = svc_bits;
      if (irq_ret)
      begin
        // Restore the previous level
        if (b[2])
          b[2] = 1'b0;
        else if (b[1])
          b[1] = 1'b0;
        else
          b[0] = 1'b0;
      end
      if (irq_ack && irq_req)
        b[int'(irq_level) - 1] = 1'b1;
      svc_bits <= b;
    end
  end

  // ----------------------------------------------------------------
  // Request to the core; held off the cycle after an accept
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irq_req <= 1'b0;
      irq_vec_addr <= VEC_BASE;
      irq_level <= LVL_NONE;
    end
    else if (ce)
    begin
      irq_req <= win_valid && !irq_ack && !irq_ret;
      irq_level <= win_valid ? win_lvl : LVL_NONE;
      // Eight bytes per vector from the base
      irq_vec_addr <= VEC_BASE + (17'(win_vec) << VEC_STEP_SHIFT);
    end
  end

  // ----------------------------------------------------------------
  // Wake causes
  // ----------------------------------------------------------------
  assign sys_wake = !ext_reset_n || wdt_reset || low_voltage_detect;
  // Pins zero/one count only in level mode
  assign hold_wake = (active[SRC_EXT0] && ext_level[0])
                     || (active[SRC_EXT1] && ext_level[1])
                     || active[SRC_EXT2] || active[SRC_EXT4]
                     || active[SRC_EXT5] || active[SRC_PORT0];
  assign xhold_wake = active[SRC_BT0] || active[SRC_BT1] || active[SRC_REMOTE];

  // ----------------------------------------------------------------
  // Standby sequencer
  // ----------------------------------------------------------------
  pisw_standby u_stby (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .ce(ce),
    .enter(stby_enter),
    .enter_mode(pisw_mode_t'(reg_wdata[1:0])),
    .sys_wake(sys_wake),
    .irq_wake(win_valid),
    .hold_wake(hold_wake),
    .xhold_wake(xhold_wake),
    .osc_ctl(osc_ctl),
    .mode(stby_mode),
    .cpu_run(cpu_run),
    .periph_run(periph_run),
    .base_timer_run(base_timer_run),
    .osc_cf_en(osc_cf_en),
    .osc_rc_en(osc_rc_en),
    .osc_xt_en(osc_xt_en)
  );

  // ----------------------------------------------------------------
  // Read mux; unmapped offsets read zero
  // ----------------------------------------------------------------
  always_comb
  begin
    case (reg_addr)
      OFS_FLAG0, OFS_FLAG1, OFS_FLAG2: next_rdata = byte_of(pend, reg_addr[1:0]);
      OFS_EN0: next_rdata = src_en[7:0];
      OFS_EN1: next_rdata = src_en[15:8];
      OFS_EN2: next_rdata = src_en[23:16];
      OFS_LVL_LO: next_rdata = vec_lvl_sel[7:0];
      OFS_LVL_HI: next_rdata = {4'h0, ext_level, vec_lvl_sel[9:8]};
      OFS_STBY: next_rdata = {6'h00, stby_mode};
      OFS_OSC: next_rdata = {5'h00, osc_ctl};
      OFS_SVC: next_rdata = {win_vec, 1'b0, svc_bits};
      OFS_LIST_SEL: next_rdata = {4'h0, list_sel};
      OFS_LIST: next_rdata = flag_list;
      default: next_rdata = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------
  // Read data register, valid the cycle after the strobe only
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      reg_rdata <= 8'h00;
    else if (ce)
      reg_rdata <= reg_rd ? next_rdata : 8'h00;
  end

endmodule : pisw_top
